/* logic/ucirq_pkg.sv */
package ucirq_pkg;
    // Byte addresses of the register words on the bus.
    localparam logic [4:0] ADDR_MASK = 5'h00;
    localparam logic [4:0] ADDR_STATUS = 5'h04;
    localparam logic [4:0] ADDR_LINE = 5'h08;
    localparam logic [4:0] ADDR_MODEM = 5'h0c;
    localparam logic [4:0] ADDR_CTRL = 5'h10;
    localparam int ADDR_W = 5;

    // Field positions of the interrupt mask.
    localparam int MASK_RX = 0;
    localparam int MASK_TX = 1;
    localparam int MASK_LINE = 2;
    localparam int MASK_MODEM = 3;
    localparam int MASK_SLEEP = 4;
    localparam int MASK_XOFF = 5;
    localparam int MASK_RTS = 6;
    localparam int MASK_CTS = 7;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] MASK_ENH_BITS = 8'hf0;

    // Field positions of the control word.
    localparam int CTRL_FIFO_EN = 0;
    localparam int CTRL_ENH_EN = 1;
    localparam int CTRL_AUTO_RTS = 2;
    localparam int CTRL_AUTO_CTS = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // Six-bit source codes, highest priority first.
    localparam logic [5:0] CODE_LINE = 6'h06;
    localparam logic [5:0] CODE_TIMEOUT = 6'h0c;
    localparam logic [5:0] CODE_RX = 6'h04;
    localparam logic [5:0] CODE_TX = 6'h02;
    localparam logic [5:0] CODE_MODEM = 6'h00;
    localparam logic [5:0] CODE_XOFF = 6'h10;
    localparam logic [5:0] CODE_FLOW = 6'h20;
    localparam logic [5:0] CODE_NONE = 6'h01;

    // Receive timeout: four character times plus twelve bit times.
    localparam int TIMEOUT_CHARS = 4;
    localparam int TIMEOUT_BITS = 12;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* logic/ucirq_ctrl.sv */
// How it works
// - FIFO mode raises receive interrupt at trigger.
// - Data ready set on push, cleared empty.
// - FIFO on and mask bits 0-3 clear: polled.
// - Line state reports overrun, errors, transmit empties.
// - Mask bit 0 enables receive data interrupt.
// - Mask bit 1 raises transmit ready, also when set.
// - Overrun at once, char errors at head.
// - Mask bit 3 raises modem interrupt on deltas.
// - Mask bits 4-7 writable only when enhanced.
// - RTS rising raises interrupt under auto RTS.
// - CTS rising raises interrupt under auto CTS.
// - Status read returns highest priority pending source.
// - Timeout after four chars plus twelve bits.
// - Line read clears bits 1-4, not 7.
// - Receive clears below trigger; timeout on pop.
// - Transmit cleared by status read or push.
// - Modem read clears modem and flow interrupts.
// - Xoff or special match raises interrupt.
// - Status read clears Xoff; special also next char.
// - Reset clears every mask bit and sleep.
// - Status bit 0 low while anything pending.
// - Fixed priority order and six-bit codes.
// - Status bits 7 and 6 show FIFO enable.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
module ucirq_ctrl #(
    parameter int LVL_W = 7
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic [ucirq_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ucirq_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [LVL_W-1:0] RX_LEVEL,
    input wire logic [LVL_W-1:0] RX_TRIG,
    input wire logic RX_PUSH,
    input wire logic RX_POP,
    input wire logic RX_OVERRUN,
    input wire logic RX_HEAD_NEW,
    input wire logic [2:0] RX_HEAD_ERR,
    input wire logic RX_FIFO_HAS_ERR,
    input wire logic [LVL_W-1:0] TX_LEVEL,
    input wire logic [LVL_W-1:0] TX_TRIG,
    input wire logic TX_PUSH,
    input wire logic TX_SHIFT_EMPTY,
    input wire logic BIT_TICK,
    input wire logic [3:0] CHAR_BITS,
    input wire logic [3:0] MODEM_LVL,
    input wire logic [3:0] MODEM_CHG,
    input wire logic XOFF_MATCH,
    input wire logic SPECIAL_MATCH,
    input wire logic RTS_LVL,
    input wire logic CTS_N,
    output logic IRQ,
    output logic POLLED_MODE,
    output logic SLEEP_EN
);
    import ucirq_pkg::*;

    // Picks the code of the highest pending source; order is fixed.
    function automatic logic [5:0] pick_code(input logic [6:0] p);
        logic [5:0] c;
        c = CODE_NONE;
        if (p[0]) c = CODE_LINE;
        else if (p[1]) c = CODE_TIMEOUT;
        else if (p[2]) c = CODE_RX;
        else if (p[3]) c = CODE_TX;
        else if (p[4]) c = CODE_MODEM;
        else if (p[5]) c = CODE_XOFF;
        else if (p[6]) c = CODE_FLOW;
        return c;
    endfunction

    logic [7:0] mask_reg, mask_next;
    logic [3:0] ctrl_reg;
    logic [3:0] line_err_reg;
    logic [3:0] delta_reg;
    logic tx_pend_reg, to_pend_reg, xoff_pend_reg, spc_pend_reg;
    logic rts_pend_reg, cts_pend_reg;
    logic tx_cond_reg, rts_prev_reg;
    logic cts_s1_reg, cts_s2_reg, cts_s3_reg, cts_lvl_reg;
    logic [7:0] to_cnt_reg;
    logic aw_got_reg, w_got_reg;
    logic [ADDR_W-1:0] waddr_reg;
    logic [7:0] wdata_reg;
    logic wbyte_reg;

    // Mode and condition decode.
    wire fifo_en = ctrl_reg[CTRL_FIFO_EN];
    wire enh_en = ctrl_reg[CTRL_ENH_EN];
    wire rx_cond = fifo_en ? (RX_LEVEL >= RX_TRIG) : (RX_LEVEL != '0);
    wire tx_cond = fifo_en ? (TX_LEVEL < TX_TRIG) : (TX_LEVEL == '0);
    wire [9:0] to_limit = 10'(TIMEOUT_CHARS) * 10'(CHAR_BITS) + 10'(TIMEOUT_BITS);
    wire to_run = fifo_en && (RX_LEVEL != '0) && !RX_PUSH && !RX_POP;

    // Line state word, bit 0 follows the FIFO fill directly.
    wire [7:0] line_word = {RX_FIFO_HAS_ERR,
                            (TX_LEVEL == '0) && TX_SHIFT_EMPTY,
                            TX_LEVEL == '0,
                            line_err_reg,
                            RX_LEVEL != '0};

    // Enabled pending sources in priority order.
    wire [6:0] pend = {
        (rts_pend_reg || cts_pend_reg),
        mask_reg[MASK_XOFF] && (xoff_pend_reg || spc_pend_reg),
        mask_reg[MASK_MODEM] && (delta_reg != 4'h0),
        mask_reg[MASK_TX] && tx_pend_reg,
        mask_reg[MASK_RX] && rx_cond,
        mask_reg[MASK_RX] && to_pend_reg,
        mask_reg[MASK_LINE] && (line_err_reg != 4'h0)};
    wire [5:0] cur_code = pick_code(pend);

    // Bus handshakes and the accesses they carry.
    wire ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
    wire w_do = aw_got_reg && w_got_reg && !S_AXI_BVALID;
    wire rd_status = ar_hs && (S_AXI_ARADDR == ADDR_STATUS);
    wire rd_line = ar_hs && (S_AXI_ARADDR == ADDR_LINE);
    wire rd_modem = ar_hs && (S_AXI_ARADDR == ADDR_MODEM);
    wire wr_mask = w_do && wbyte_reg && (waddr_reg == ADDR_MASK);
    wire wr_ctrl = w_do && wbyte_reg && (waddr_reg == ADDR_CTRL);
    wire w_mapped = (waddr_reg == ADDR_MASK) || (waddr_reg == ADDR_CTRL);
    wire r_mapped = (S_AXI_ARADDR == ADDR_MASK) || (S_AXI_ARADDR == ADDR_STATUS)
                    || (S_AXI_ARADDR == ADDR_LINE) || (S_AXI_ARADDR == ADDR_MODEM)
                    || (S_AXI_ARADDR == ADDR_CTRL);

    // The upper mask bits keep their value unless enhanced mode is on.
    assign mask_next = enh_en ? wdata_reg
                              : ((mask_reg & MASK_ENH_BITS) | (wdata_reg & ~MASK_ENH_BITS));

    // Read data mux; status reads carry FIFO enable in bits 7 and 6.
    wire [7:0] rd_byte =
        (S_AXI_ARADDR == ADDR_MASK) ? mask_reg :
        (S_AXI_ARADDR == ADDR_STATUS) ? {fifo_en, fifo_en, cur_code} :
        (S_AXI_ARADDR == ADDR_LINE) ? line_word :
        (S_AXI_ARADDR == ADDR_MODEM) ? {MODEM_LVL, delta_reg} :
        (S_AXI_ARADDR == ADDR_CTRL) ? {4'h0, ctrl_reg} : 8'h00;

    // Flow events: RTS is our own logic, CTS comes from a pin.
    wire rts_rise = RTS_LVL && !rts_prev_reg;
    wire cts_rise = (cts_s2_reg == cts_s3_reg) && cts_s3_reg && !cts_lvl_reg;

    // Write channel: address and data are taken in either order.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= 8'h00;
            wbyte_reg <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= !aw_got_reg && !(S_AXI_AWVALID && S_AXI_AWREADY);
            S_AXI_WREADY <= !w_got_reg && !(S_AXI_WVALID && S_AXI_WREADY);
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got_reg <= 1'b1;
                waddr_reg <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got_reg <= 1'b1;
                wdata_reg <= S_AXI_WDATA[7:0];
                wbyte_reg <= S_AXI_WSTRB[0];
            end
            if (w_do) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= w_mapped ? RESP_OKAY : RESP_SLVERR;
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                S_AXI_AWREADY <= 1'b0;
                S_AXI_WREADY <= 1'b0;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
        end
    end

    // Read channel: one read in flight; its side effects act on the address edge.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= RESP_OKAY;
        end else if (ar_hs) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= {24'h00_0000, rd_byte};
            S_AXI_RRESP <= r_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end else begin
            S_AXI_ARREADY <= !S_AXI_RVALID;
        end
    end

    // Software settings; the reset value leaves every source masked.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            mask_reg <= MASK_RESET;
            ctrl_reg <= CTRL_RESET;
        end else begin
            if (wr_mask) mask_reg <= mask_next;
            if (wr_ctrl) ctrl_reg <= wdata_reg[3:0];
        end
    end

    // Line errors: overrun at once, character errors as the byte reaches the head.
    // A new error in the clearing cycle survives, since set wins over clear.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            line_err_reg <= 4'h0;
        end else begin
            line_err_reg <= (rd_line ? 4'h0 : line_err_reg)
                            | {RX_HEAD_NEW ? RX_HEAD_ERR : 3'h0, RX_OVERRUN};
        end
    end

    // Modem deltas are sticky until the modem word is read.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            delta_reg <= 4'h0;
        end else begin
            delta_reg <= (rd_modem ? 4'h0 : delta_reg) | MODEM_CHG;
        end
    end

    // Receive timeout counts bit ticks of silence while data waits.
    // Any push or pop restarts it, so an active stream never times out.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            to_cnt_reg <= 8'h00;
            to_pend_reg <= 1'b0;
        end else begin
            if (!to_run) to_cnt_reg <= 8'h00;
            else if (BIT_TICK && !to_pend_reg) to_cnt_reg <= to_cnt_reg + 8'h01;
            if (to_run && ({2'b00, to_cnt_reg} >= to_limit)) to_pend_reg <= 1'b1;
            else if (RX_POP) to_pend_reg <= 1'b0;
        end
    end

    // Transmit ready is an event: a rising condition or enabling while it holds.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            tx_cond_reg <= 1'b0;
            tx_pend_reg <= 1'b0;
        end else begin
            tx_cond_reg <= tx_cond;
            if ((tx_cond && !tx_cond_reg)
                || (wr_mask && mask_next[MASK_TX] && !mask_reg[MASK_TX] && tx_cond)) begin
                tx_pend_reg <= 1'b1;
            end else if (TX_PUSH || (rd_status && cur_code == CODE_TX)) begin
                tx_pend_reg <= 1'b0;
            end
        end
    end

    // Xoff and special character flags; the special one also ends on the next byte.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            xoff_pend_reg <= 1'b0;
            spc_pend_reg <= 1'b0;
        end else begin
            if (XOFF_MATCH) xoff_pend_reg <= 1'b1;
            else if (rd_status && cur_code == CODE_XOFF) xoff_pend_reg <= 1'b0;
            if (SPECIAL_MATCH) spc_pend_reg <= 1'b1;
            else if (RX_PUSH || (rd_status && cur_code == CODE_XOFF)) spc_pend_reg <= 1'b0;
        end
    end

    // CTS pin passes three flops; a change counts once the last two agree.
    // They reset to the released high level, so leaving reset makes no false rise.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            cts_s1_reg <= 1'b1;
            cts_s2_reg <= 1'b1;
            cts_s3_reg <= 1'b1;
            cts_lvl_reg <= 1'b1;
            rts_prev_reg <= 1'b0;
        end else begin
            cts_s1_reg <= CTS_N;
            cts_s2_reg <= cts_s1_reg;
            cts_s3_reg <= cts_s2_reg;
            if (cts_s2_reg == cts_s3_reg) cts_lvl_reg <= cts_s3_reg;
            rts_prev_reg <= RTS_LVL;
        end
    end

    // Flow transition flags, armed only with the matching auto mode.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            rts_pend_reg <= 1'b0;
            cts_pend_reg <= 1'b0;
        end else begin
            if (rts_rise && mask_reg[MASK_RTS] && ctrl_reg[CTRL_AUTO_RTS]) begin
                rts_pend_reg <= 1'b1;
            end else if (rd_modem) begin
                rts_pend_reg <= 1'b0;
            end
            if (cts_rise && mask_reg[MASK_CTS] && ctrl_reg[CTRL_AUTO_CTS]) begin
                cts_pend_reg <= 1'b1;
            end else if (rd_modem) begin
                cts_pend_reg <= 1'b0;
            end
        end
    end

    // Registered outputs toward the rest of the channel and the host.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            IRQ <= 1'b0;
            POLLED_MODE <= 1'b0;
            SLEEP_EN <= 1'b0;
        end else begin
            IRQ <= (pend != 7'h00);
            POLLED_MODE <= fifo_en && (mask_reg[3:0] == 4'h0);
            SLEEP_EN <= mask_reg[MASK_SLEEP];
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    reset_masks_a: assert property ($rose(!SYS_RST) |-> mask_reg == 8'h00)
        else $error("Mask not cleared by reset.");
    irq_follows_a: assert property ((pend != 7'h00) |=> IRQ)
        else $error("IRQ missing while a source is pending.");
    idle_code_a: assert property (S_AXI_RVALID && $past(rd_status) && $past(pend) == 7'h00
                                  |-> S_AXI_RDATA[0])
        else $error("Status bit 0 low with nothing pending.");
    fifo_bits_a: assert property (S_AXI_RVALID && $past(rd_status)
                                  |-> S_AXI_RDATA[7:6] == {2{$past(fifo_en)}})
        else $error("Status bits 7 and 6 disagree with FIFO enable.");
    line_first_a: assert property (rd_status && pend[0]
                                   |=> S_AXI_RDATA[5:0] == 6'h06)
        else $error("Line status not reported first.");
    line_clear_a: assert property (rd_line && !RX_OVERRUN && !RX_HEAD_NEW
                                   |=> line_err_reg == 4'h0)
        else $error("Line read did not clear error bits.");
    overrun_now_a: assert property (RX_OVERRUN && mask_reg[MASK_LINE] && !wr_mask
                                    |=> pend[0] ##1 IRQ)
        else $error("Overrun did not raise line interrupt at once.");
    enh_guard_a: assert property (wr_mask && !enh_en
                                  |=> mask_reg[7:4] == $past(mask_reg[7:4]))
        else $error("Upper mask bits changed outside enhanced mode.");
    tx_clear_a: assert property (TX_PUSH && !(tx_cond && !tx_cond_reg) && !wr_mask
                                 |=> !tx_pend_reg)
        else $error("Transmit push did not clear transmit ready.");
    modem_clear_a: assert property (rd_modem && !rts_rise && !cts_rise
                                    |=> !rts_pend_reg && !cts_pend_reg)
        else $error("Modem read left a flow interrupt pending.");
    timeout_pop_a: assert property (to_pend_reg && RX_POP |=> !to_pend_reg)
        else $error("Receive pop did not clear timeout.");

    write_seen_c: cover property (w_do && wr_mask);
    timeout_c: cover property ($rose(to_pend_reg));
    flow_c: cover property ($rose(cts_pend_reg));
    tx_enable_c: cover property ($rose(tx_pend_reg) && $past(wr_mask));
endmodule

/* tb/ucirq_host.sv */
// Host processor model: an AXI4-Lite master with one transfer at a time.
module ucirq_host (
    input wire logic clk,
    output logic [4:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [4:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready,
    output logic tmo
);
    timeunit 1ns;
    timeprecision 1ns;

    // The bus starts idle.
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, tmo} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
    end

    // Both write channels go out together and each drops once taken.
    task automatic wr(input logic [4:0] a, input logic [7:0] v, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, v};
        wstrb <= 4'h1;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 40);
        r = bresp;
        bready <= 1'b0;
        // Released payload is scrambled so that nothing leans on stale values.
        awaddr <= ~a;
        wdata <= ~{24'h0, v};
        if (n >= 40) tmo <= 1'b1;
    endtask

    // A read holds its address until taken and rready until the data comes.
    task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 40);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
        araddr <= ~a;
        if (n >= 40) tmo <= 1'b1;
    endtask
endmodule

/* tb/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ucirq_pkg::*;
    logic clk, rst, tmo, irq, polled, sleep, ferr, tse, rts, cts_n;
    logic [4:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb, cbits, mlvl, mc;
    logic [1:0] bresp, rresp, r;
    logic [6:0] rxl, rxt, txl, txt, t;
    logic [2:0] herr;
    logic [11:0] ev;
    int fails, n_tests, n;

    ucirq_host host (.*);
    ucirq_ctrl dut (.SYS_CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .RX_LEVEL(rxl), .RX_TRIG(rxt), .RX_PUSH(ev[0]),
        .RX_POP(ev[1]), .RX_OVERRUN(ev[2]), .RX_HEAD_NEW(ev[3]), .RX_HEAD_ERR(herr),
        .RX_FIFO_HAS_ERR(ferr), .TX_LEVEL(txl), .TX_TRIG(txt), .TX_PUSH(ev[4]),
        .TX_SHIFT_EMPTY(tse), .BIT_TICK(ev[5]), .CHAR_BITS(cbits), .MODEM_LVL(mlvl),
        .MODEM_CHG(ev[11:8]), .XOFF_MATCH(ev[6]), .SPECIAL_MATCH(ev[7]),
        .RTS_LVL(rts), .CTS_N(cts_n), .IRQ(irq), .POLLED_MODE(polled), .SLEEP_EN(sleep));

    // Free-running 20 MHz clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic end_sim();
        $display("compares %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // A stuck bus handshake counts as a mismatch and ends the run.
    always @(posedge tmo) begin
        fails++;
        end_sim();
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cb(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask

    task automatic rc(input logic [4:0] a, input logic [7:0] e, input string nm);
        host.rd(a, d, r);
        chk(nm, {24'h0, e}, d);
    endtask

    task automatic w(input logic [4:0] a, input logic [7:0] v);
        host.wr(a, v, r);
        chk("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    // Event pulses last one cycle and are never back to back.
    task automatic pl(input logic [11:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= '0;
    endtask

    // Status word expected from FIFO enable and pending set, line first.
    function automatic logic [7:0] st(input logic f, input logic [6:0] p);
        logic [5:0] c;
        c = p[6] ? CODE_LINE : p[5] ? CODE_TIMEOUT : p[4] ? CODE_RX : p[3] ? CODE_TX :
            p[2] ? CODE_MODEM : p[1] ? CODE_XOFF : p[0] ? CODE_FLOW : CODE_NONE;
        return {f, f, c};
    endfunction

    function automatic logic [7:0] lx(input logic o, input logic [2:0] e);
        return {ferr, (txl == 7'h0) && tse, txl == 7'h0, e, o, rxl != 7'h0};
    endfunction

    initial begin
        {fails, n_tests} = '0;
        {ev, rxl, herr, ferr, tse, mlvl, rts} = '0;
        {rst, cts_n, rxt, txl, txt, cbits} = {2'h3, 7'h1, 7'h1, 7'h1, 4'ha};
        void'($urandom(68683));
        mlvl = 4'($urandom);
        tse = 1'($urandom);
        tick(6);
        rst <= 1'b0;
        tick(2);
        rc(ADDR_MASK, MASK_RESET, "mask reset");
        rc(ADDR_STATUS, st(0, 0), "status reset");
        cb("sleep reset", 0, sleep);
        host.rd(5'h14, d, r);
        chk("unmapped", {RESP_SLVERR, 30'h0}, {r, d[29:0]});
        host.wr(5'h14, 8'h55, r);
        chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
        $display("test reset done");
        w(ADDR_MASK, 8'hf0);
        rc(ADDR_MASK, 8'h00, "mask gated");
        w(ADDR_CTRL, 8'h02);
        w(ADDR_MASK, 8'h10);
        tick(1);
        cb("sleep", 1, sleep);
        $display("test enhanced done");
        w(ADDR_CTRL, 8'h03);
        w(ADDR_MASK, 8'h00);
        tick(2);
        cb("polled", 1, polled);
        rc(ADDR_STATUS, st(1, 0), "fifo status");
        for (int i = 0; i < 4; i++) begin
            w(ADDR_MASK, 8'h1 << i);
            tick(2);
            cb("not polled", 0, polled);
        end
        $display("test polled done");
        w(ADDR_MASK, 8'h01);
        repeat (4) begin
            t = 7'($urandom_range(60, 2));
            rxt <= t;
            rxl <= t;
            pl(12'h001);
            tick(2);
            rc(ADDR_STATUS, st(1, 7'h10), "rx trigger");
            cb("irq rx", 1, irq);
            rxl <= t - 7'h1;
            tick(3);
            rc(ADDR_STATUS, st(1, 0), "rx below");
            rc(ADDR_LINE, lx(0, 0), "data ready");
        end
        rxl <= 7'h0;
        tick(2);
        rc(ADDR_LINE, lx(0, 0), "fifo empty");
        $display("test receive done");
        w(ADDR_MASK, 8'h04);
        herr <= 3'($urandom_range(7, 1));
        ferr <= 1'b1;
        pl(12'h00c);
        tick(2);
        rc(ADDR_STATUS, st(1, 7'h40), "line code");
        rc(ADDR_LINE, lx(1, herr), "line bits");
        rc(ADDR_LINE, lx(0, 0), "line cleared");
        rc(ADDR_STATUS, st(1, 0), "line gone");
        ferr <= 1'b0;
        $display("test line done");
        w(ADDR_CTRL, 8'h02);
        w(ADDR_MASK, 8'h0d);
        mc = 4'($urandom_range(15, 1));
        txl <= 7'h0;
        rxl <= 7'h1;
        pl({mc, 8'h04});
        w(ADDR_MASK, 8'h0f);
        tick(2);
        rc(ADDR_STATUS, st(0, 7'h5c), "top line");
        rc(ADDR_LINE, lx(1, 0), "line read");
        rc(ADDR_STATUS, st(0, 7'h1c), "then rx");
        rxl <= 7'h0;
        tick(2);
        rc(ADDR_STATUS, st(0, 7'h0c), "then tx");
        rc(ADDR_STATUS, st(0, 7'h04), "then modem");
        rc(ADDR_MODEM, {mlvl, mc}, "modem word");
        rc(ADDR_STATUS, st(0, 0), "all clear");
        cb("irq idle", 0, irq);
        txl <= 7'h1;
        tick(2);
        txl <= 7'h0;
        tick(3);
        cb("tx again", 1, irq);
        pl(12'h010);
        tick(2);
        cb("tx pushed", 0, irq);
        w(ADDR_MASK, 8'h00);
        w(ADDR_MASK, 8'h02);
        tick(1);
        cb("tx enable", 1, irq);
        pl(12'h010);
        txl <= 7'h1;
        $display("test priority done");
        w(ADDR_MASK, 8'h20);
        pl(12'h040);
        tick(2);
        rc(ADDR_STATUS, st(0, 7'h02), "xoff code");
        rc(ADDR_STATUS, st(0, 0), "xoff read");
        pl(12'h080);
        tick(2);
        cb("special", 1, irq);
        pl(12'h001);
        tick(2);
        cb("special next", 0, irq);
        $display("test xoff done");
        w(ADDR_CTRL, 8'h0e);
        w(ADDR_MASK, 8'hc0);
        rts <= 1'b1;
        tick(3);
        rc(ADDR_STATUS, st(0, 7'h01), "rts rise");
        rc(ADDR_MODEM, {mlvl, 4'h0}, "modem flow");
        rc(ADDR_STATUS, st(0, 0), "flow read");
        cts_n <= 1'b0;
        tick(6);
        cts_n <= 1'b1;
        tick(8);
        rc(ADDR_STATUS, st(0, 7'h01), "cts rise");
        rc(ADDR_MODEM, {mlvl, 4'h0}, "modem cts");
        w(ADDR_CTRL, 8'h02);
        rts <= 1'b0;
        tick(2);
        rts <= 1'b1;
        tick(3);
        cb("no auto rts", 0, irq);
        $display("test flow done");
        w(ADDR_CTRL, 8'h03);
        w(ADDR_MASK, 8'h01);
        cbits <= 4'($urandom_range(11, 7));
        rxl <= 7'h1;
        rxt <= 7'h8;
        pl(12'h001);
        n = 4 * int'(cbits) + 12;
        repeat (n - 1) pl(12'h020);
        tick(2);
        cb("timeout early", 0, irq);
        pl(12'h020);
        tick(2);
        rc(ADDR_STATUS, st(1, 7'h20), "timeout");
        pl(12'h002);
        tick(2);
        rc(ADDR_STATUS, st(1, 0), "timeout pop");
        txt <= 7'h8;
        w(ADDR_MASK, 8'h02);
        tick(2);
        rc(ADDR_STATUS, st(1, 7'h08), "tx fifo");
        rc(ADDR_STATUS, st(1, 0), "tx read");
        $display("test timeout done");
        end_sim();
    end
endmodule
